/* File: hdl/lst_pkg.sv */
package lst_pkg;

  // clock and list timebase
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

  // dwell limits in list ticks of one microsecond
  localparam logic [15:0] DWELL_MIN_US = 16'h005D;
  localparam logic [15:0] DWELL_MAX_US = 16'h84D0;

  // table geometry
  localparam int IDX_W = 13;
  localparam logic [12:0] LIST_DEPTH = 13'h170C;

  // setpoint magnitude limit of the model, plain default
  localparam logic signed [15:0] SP_LIMIT = 16'sh7000;

  // reset values
  localparam logic [15:0] TRIG_RST = 16'h0000;
  localparam logic [7:0] COUNT_RST = 8'h01;
  localparam logic [7:0] SKIP_RST = 8'h00;

  // error queue codes
  localparam logic [31:0] ERR_NONE = 32'h0000_0000;
  localparam logic [31:0] ERR_RANGE = 32'hFFFF_FF22;
  localparam logic [31:0] ERR_CONFLICT = 32'hFFFF_FF23;

  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_OUT = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_SKIP = 8'h14;
  localparam logic [7:0] OFS_STEP = 8'h18;
  localparam logic [7:0] OFS_DWELL = 8'h1C;
  localparam logic [7:0] OFS_QSTART = 8'h20;
  localparam logic [7:0] OFS_QDATA = 8'h24;
  localparam logic [7:0] OFS_RES_DWELL = 8'h28;
  localparam logic [7:0] OFS_RES_POINTS = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  localparam logic [7:0] OFS_ERROR = 8'h34;

  // field positions
  localparam int MODE_PEND_BIT = 4;
  localparam int ST_RUNNING = 0;
  localparam int ST_LIMIT_ERR = 1;
  localparam int ST_OUT_OFF = 2;
  localparam int ST_ERR_PEND = 3;
  localparam int ST_HALT_PEND = 4;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    LST_MODE_VOLT = 2'h0,
    LST_MODE_CURR = 2'h1,
    LST_MODE_EXT = 2'h2
  } lst_mode_t;

  typedef enum logic [1:0] {SQ_IDLE, SQ_STEP, SQ_HOLD} lst_seq_t;

  // command strobes, bit 0 is trigger
  typedef struct packed {
    logic dev_reset;
    logic halt_req;
    logic fixed_req;
    logic run_req;
    logic list_clear;
    logic trigger;
  } lst_cmd_t;

  localparam int CMD_W = $bits(lst_cmd_t);

endpackage

/* File: hdl/lst_dwell_timer.sv */
`timescale 1ns/1ps
module lst_dwell_timer
  import lst_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] hold_us,
  // completion
  output logic done
);

  logic [4:0] pre_q;
  logic [15:0] remain_q;
  logic busy_q;
  logic tick;

  // prescaler restarts with each step so every dwell is exact
  assign tick = busy_q && (pre_q == TICK_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || start || !busy_q || tick) begin
      pre_q <= 5'h00;
    end else begin
      pre_q <= pre_q + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      remain_q <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
      end else if (start) begin
        busy_q <= 1'b1;
        remain_q <= hold_us;
      end else if (tick) begin
        if (remain_q <= 16'h0001) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else begin
          remain_q <= remain_q - 16'h0001;
        end
      end
    end
  end

endmodule

/* File: hdl/lst_list_sequencer.sv */
`timescale 1ns/1ps
// Summary of operation
// - trigger copies stored triggered setpoint to output; readback gives stored value
// - triggered setpoint beyond model limit is refused, posting data-out-of-range error
// - operating mode is voltage, current or external; it picks regulated quantity
// - voltage mode flags current limit; current mode flags voltage limit
// - operating mode reads 0 for voltage, 1 for current
// - separate pending mode becomes operating mode on trigger
// - pending mode reads 0 for voltage, 1 for current
// - list clear sets every list pointer to zero, emptying both tables
// - list clear releases list control of the output-off flag
// - repeat count 1 to 255 sets number of passes
// - repeat count zero loops until fixed-setpoint, device reset or halt request
// - first pass is complete; later passes start after the skipped steps
// - list clear also zeroes the skip value
// - each entry goes to next free location; count reads next location
// - single dwell at location 0 applies to every step
// - steps run in ascending order, wrapping to the first location after the skipped steps
// - run refused with conflict error when step table is empty, or table sizes differ and dwell table does not hold exactly one entry
// - list commands and queries refused with conflict error while running
// - fixed-setpoint request stops list, last step setting stays
// - query start pointer sets first reported location; zero after clear
// - resolution query returns min dwell, max dwell, total points
// - device reset command stops any running list
// - halt request stops at end of current pass, last step stays
module lst_list_sequencer
  import lst_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // output stage status
  input wire logic current_limit_hit,
  input wire logic voltage_limit_hit,
  // output stage control
  output logic [15:0] output_setpoint,
  output logic [1:0] regulation_mode,
  output logic limit_error,
  output logic list_holds_output_off,
  output logic sequence_running
);

  function automatic logic is_list_reg(input logic [ADDR_W-1:0] a);
    return (a == OFS_COUNT) || (a == OFS_SKIP) || (a == OFS_STEP) ||
           (a == OFS_DWELL) || (a == OFS_QSTART) || (a == OFS_QDATA) ||
           (a == OFS_RES_DWELL) || (a == OFS_RES_POINTS);
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_ERROR);
  endfunction

  function automatic logic sp_in_range(input logic [15:0] v);
    return ($signed(v) <= SP_LIMIT) && ($signed(v) >= -SP_LIMIT);
  endfunction

  // bus state
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write, ar_fire;

  // control and list state
  logic [15:0] trig_q, out_sp_q;
  lst_mode_t op_mode_q;
  logic pend_curr_q;
  logic [7:0] rep_q, skip_q, pass_q;
  logic [IDX_W-1:0] pt_cnt_q, dw_cnt_q, qptr_q, idx_q;
  logic [15:0] step_tab [0:int'(LIST_DEPTH)-1];
  logic [15:0] dw_tab [0:int'(LIST_DEPTH)-1];
  lst_seq_t seq_q;
  logic halt_pend_q, out_off_q, limit_err_q;
  logic [31:0] err_q;

  // decode results
  lst_cmd_t cmd;
  logic wr_trig, wr_mode, wr_count, wr_skip, wr_step, wr_dwell, wr_qstart;
  logic [1:0] wr_resp, rd_resp;
  logic w_err_set, r_err_set;
  logic [31:0] w_err_val, rd_val;

  // sequencer helpers
  logic running, balanced, last_step, pass_stop, stop_req, tmr_done;
  logic [IDX_W-1:0] next_start;
  logic [15:0] step_hold;

  assign running = (seq_q != SQ_IDLE);
  assign balanced = (pt_cnt_q != '0) &&
                    ((dw_cnt_q == pt_cnt_q) || (dw_cnt_q == 13'h0001));
  assign last_step = (idx_q == pt_cnt_q - 13'h0001);
  assign pass_stop = halt_pend_q ||
                     ((rep_q != 8'h00) && (pass_q + 8'h01 == rep_q));
  // a skip that swallows the whole list falls back to a full pass
  assign next_start = ({5'h00, skip_q} < pt_cnt_q) ? {5'h00, skip_q} : '0;
  assign step_hold = (dw_cnt_q == 13'h0001) ? dw_tab[0] : dw_tab[idx_q];
  assign stop_req = cmd.fixed_req || cmd.dev_reset;

  // ---------------- axi write channel ----------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_resp;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // write decode; strobes all low make a write a no-op
  always_comb begin
    cmd = '0;
    wr_trig = 1'b0;
    wr_mode = 1'b0;
    wr_count = 1'b0;
    wr_skip = 1'b0;
    wr_step = 1'b0;
    wr_dwell = 1'b0;
    wr_qstart = 1'b0;
    wr_resp = RESP_OKAY;
    w_err_set = 1'b0;
    w_err_val = ERR_RANGE;
    if (do_write) begin
      if (!is_mapped(aw_addr_q)) begin
        wr_resp = RESP_DECERR;
      end else if (w_strb_q == 4'h0) begin
        wr_resp = RESP_OKAY;
      end else if (running && is_list_reg(aw_addr_q)) begin
        w_err_set = 1'b1;
        w_err_val = ERR_CONFLICT;
        wr_resp = RESP_SLVERR;
      end else begin
        case (aw_addr_q)
          OFS_CMD: begin
            cmd = lst_cmd_t'(w_data_q[CMD_W-1:0]);
            if (running && cmd.list_clear) begin
              cmd.list_clear = 1'b0;
              w_err_set = 1'b1;
              w_err_val = ERR_CONFLICT;
            end
            if (cmd.run_req && (running || !balanced)) begin
              cmd.run_req = 1'b0;
              w_err_set = 1'b1;
              w_err_val = ERR_CONFLICT;
            end
            if (w_err_set) begin
              wr_resp = RESP_SLVERR;
            end
          end
          OFS_TRIG: begin
            wr_trig = sp_in_range(w_data_q[15:0]);
            w_err_set = !wr_trig;
          end
          OFS_MODE: begin
            wr_mode = (w_data_q[1:0] != 2'h3);
            w_err_set = !wr_mode;
          end
          OFS_COUNT: wr_count = 1'b1;
          OFS_SKIP: wr_skip = 1'b1;
          OFS_STEP: begin
            wr_step = sp_in_range(w_data_q[15:0]) && (pt_cnt_q < LIST_DEPTH);
            w_err_set = !wr_step;
          end
          OFS_DWELL: begin
            wr_dwell = (w_data_q[15:0] >= DWELL_MIN_US) &&
                       (w_data_q[15:0] <= DWELL_MAX_US) && (dw_cnt_q < LIST_DEPTH);
            w_err_set = !wr_dwell;
          end
          OFS_QSTART: wr_qstart = 1'b1;
          default: wr_resp = RESP_OKAY;
        endcase
        if (w_err_set) begin
          wr_resp = RESP_SLVERR;
        end
      end
    end
  end

  // ---------------- axi read channel ----------------
  assign s_axi_arready = !rvalid_q;
  assign ar_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    r_err_set = 1'b0;
    if (!is_mapped(s_axi_araddr)) begin
      rd_resp = RESP_DECERR;
    end else if (running && is_list_reg(s_axi_araddr)) begin
      rd_resp = RESP_SLVERR;
      r_err_set = ar_fire;
    end else begin
      case (s_axi_araddr)
        OFS_TRIG: rd_val[15:0] = trig_q;
        OFS_OUT: rd_val[15:0] = out_sp_q;
        OFS_MODE: begin
          rd_val[1:0] = op_mode_q;
          rd_val[MODE_PEND_BIT] = pend_curr_q;
        end
        OFS_COUNT: rd_val[7:0] = rep_q;
        OFS_SKIP: rd_val[7:0] = skip_q;
        OFS_STEP: rd_val[IDX_W-1:0] = pt_cnt_q;
        OFS_DWELL: rd_val[IDX_W-1:0] = dw_cnt_q;
        OFS_QSTART: rd_val[IDX_W-1:0] = qptr_q;
        OFS_QDATA: begin
          if (qptr_q < LIST_DEPTH) begin
            rd_val = {dw_tab[qptr_q], step_tab[qptr_q]};
          end
        end
        OFS_RES_DWELL: rd_val = {DWELL_MAX_US, DWELL_MIN_US};
        OFS_RES_POINTS: rd_val[IDX_W-1:0] = LIST_DEPTH;
        OFS_STATUS: begin
          rd_val[ST_RUNNING] = running;
          rd_val[ST_LIMIT_ERR] = limit_err_q;
          rd_val[ST_OUT_OFF] = out_off_q;
          rd_val[ST_ERR_PEND] = (err_q != ERR_NONE);
          rd_val[ST_HALT_PEND] = halt_pend_q;
        end
        OFS_ERROR: rd_val = err_q;
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // newest error is kept; a fresh error beats the read that clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= ERR_NONE;
    end else if (w_err_set) begin
      err_q <= w_err_val;
    end else if (r_err_set) begin
      err_q <= ERR_CONFLICT;
    end else if (ar_fire && s_axi_araddr == OFS_ERROR) begin
      err_q <= ERR_NONE;
    end
  end

  // ---------------- trigger and modes ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= TRIG_RST;
    end else if (wr_trig) begin
      trig_q <= w_data_q[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_mode_q <= LST_MODE_VOLT;
      pend_curr_q <= 1'b0;
    end else if (wr_mode) begin
      op_mode_q <= lst_mode_t'(w_data_q[1:0]);
      pend_curr_q <= w_data_q[MODE_PEND_BIT];
    end else if (cmd.trigger) begin
      op_mode_q <= pend_curr_q ? LST_MODE_CURR : LST_MODE_VOLT;
    end
  end

  // list step wins over a trigger landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_sp_q <= TRIG_RST;
    end else if (seq_q == SQ_STEP) begin
      out_sp_q <= step_tab[idx_q];
    end else if (cmd.trigger) begin
      out_sp_q <= trig_q;
    end
  end

  // external mode regulates from outside, so no limit watch there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_err_q <= 1'b0;
    end else begin
      limit_err_q <= ((op_mode_q == LST_MODE_VOLT) && current_limit_hit) ||
                     ((op_mode_q == LST_MODE_CURR) && voltage_limit_hit);
    end
  end

  // ---------------- list tables and pointers ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rep_q <= COUNT_RST;
      skip_q <= SKIP_RST;
      qptr_q <= '0;
    end else if (cmd.list_clear) begin
      skip_q <= SKIP_RST;
      qptr_q <= '0;
    end else begin
      if (wr_count) begin
        rep_q <= w_data_q[7:0];
      end
      if (wr_skip) begin
        skip_q <= w_data_q[7:0];
      end
      if (wr_qstart) begin
        qptr_q <= w_data_q[IDX_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cmd.list_clear) begin
      pt_cnt_q <= '0;
      dw_cnt_q <= '0;
    end else begin
      if (wr_step) begin
        pt_cnt_q <= pt_cnt_q + 13'h0001;
      end
      if (wr_dwell) begin
        dw_cnt_q <= dw_cnt_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_step) begin
      step_tab[pt_cnt_q] <= w_data_q[15:0];
    end
    if (wr_dwell) begin
      dw_tab[dw_cnt_q] <= w_data_q[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cmd.list_clear) begin
      out_off_q <= 1'b0;
    end else if (cmd.run_req) begin
      out_off_q <= 1'b1;
    end
  end

  // ---------------- sequencer ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn || stop_req || !running) begin
      halt_pend_q <= 1'b0;
    end else if (cmd.halt_req) begin
      halt_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= SQ_IDLE;
      idx_q <= '0;
      pass_q <= 8'h00;
    end else if (stop_req) begin
      seq_q <= SQ_IDLE;
    end else begin
      unique case (seq_q)
        SQ_IDLE: begin
          if (cmd.run_req) begin
            seq_q <= SQ_STEP;
            idx_q <= '0;
            pass_q <= 8'h00;
          end
        end
        SQ_STEP: seq_q <= SQ_HOLD;
        SQ_HOLD: begin
          if (tmr_done) begin
            if (!last_step) begin
              idx_q <= idx_q + 13'h0001;
              seq_q <= SQ_STEP;
            end else if (pass_stop) begin
              seq_q <= SQ_IDLE;
            end else begin
              idx_q <= next_start;
              pass_q <= pass_q + 8'h01;
              seq_q <= SQ_STEP;
            end
          end
        end
      endcase
    end
  end

  lst_dwell_timer u_dwell (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(seq_q == SQ_STEP),
    .abort(stop_req),
    .hold_us(step_hold),
    .done(tmr_done)
  );

  assign output_setpoint = out_sp_q;
  assign regulation_mode = op_mode_q;
  assign limit_error = limit_err_q;
  assign list_holds_output_off = out_off_q;
  assign sequence_running = running;

endmodule

/* File: test/lst_stage_model.sv */
`timescale 1ns/1ps
module lst_stage_model (
  // clock
  input wire logic aclk,
  // drive from block
  input wire logic [15:0] output_setpoint,
  // limit flags
  output logic current_limit_hit = 1'b0,
  output logic voltage_limit_hit = 1'b0
);
  // fixed resistive load, so both limits track the setpoint
  always @(posedge aclk) begin
    current_limit_hit <= $signed(output_setpoint) > 16'sh1000;
    voltage_limit_hit <= $signed(output_setpoint) > 16'sh2000;
  end
endmodule

/* File: test/lst_list_sequencer_properties.sv */
`timescale 1ns/1ps
module lst_list_sequencer_properties (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus answers
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // output stage
  input wire logic current_limit_hit,
  input wire logic voltage_limit_hit,
  input wire logic [1:0] regulation_mode,
  input wire logic limit_error,
  input wire logic list_holds_output_off,
  input wire logic sequence_running
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_limit_volt: assert property (regulation_mode == 2'h0 && current_limit_hit |=> limit_error)
    else $error("no limit error in voltage mode");
  a_limit_curr: assert property (regulation_mode == 2'h1 && voltage_limit_hit |=> limit_error)
    else $error("no limit error in current mode");
  a_limit_quiet: assert property (!((regulation_mode == 2'h0 && current_limit_hit) ||
    (regulation_mode == 2'h1 && voltage_limit_hit)) |=> !limit_error)
    else $error("limit error without cause");
  a_mode_code: assert property (regulation_mode != 2'h3)
    else $error("illegal regulation mode");
  a_run_holds_off: assert property ($rose(sequence_running) |-> ##[0:1] list_holds_output_off)
    else $error("run without output-off hold");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
endmodule
bind lst_list_sequencer lst_list_sequencer_properties u_lst_list_sequencer_properties (
  .aclk(aclk), .aresetn(aresetn), .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .current_limit_hit(current_limit_hit), .voltage_limit_hit(voltage_limit_hit),
  .regulation_mode(regulation_mode), .limit_error(limit_error),
  .list_holds_output_off(list_holds_output_off), .sequence_running(sequence_running));

/* File: test/lst_list_sequencer_test.sv */
`timescale 1ns/1ps
module lst_list_sequencer_test;
  import lst_pkg::*;
  localparam logic [7:0] RA [10] = '{OFS_TRIG, OFS_MODE, OFS_COUNT, OFS_SKIP, OFS_STEP,
    OFS_DWELL, OFS_QSTART, OFS_ERROR, OFS_RES_DWELL, OFS_RES_POINTS};
  localparam logic [31:0] RV [10] = '{0, 0, 1, 0, 0, 0, 0, 0, 32'h84D0005D, 32'h0000170C};
  localparam logic [31:0] STOPS [3] = '{32'h08, 32'h10, 32'h20};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cl, vl, lerr, off, running, track = 1'b0;
  logic [1:0] bresp, rresp, mode;
  logic [31:0] rdata;
  logic [15:0] sp, last_sp, b;
  logic [15:0] v [3];
  logic [1:0] bq [$];
  logic [33:0] rq [$];
  logic [15:0] sq [$];
  int num_errors = 0;
  int n_compared = 0;
  int seed = 76109;
  int i;
  always #25 aclk = ~aclk;
  lst_list_sequencer u_lst_list_sequencer (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .current_limit_hit(cl), .voltage_limit_hit(vl), .output_setpoint(sp),
    .regulation_mode(mode), .limit_error(lerr), .list_holds_output_off(off),
    .sequence_running(running));
  lst_stage_model u_lst_stage_model (.aclk(aclk), .output_setpoint(sp),
    .current_limit_hit(cl), .voltage_limit_hit(vl));
  task final_report;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task timeout;
    num_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    final_report;
  endtask
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // response ready goes up with the request and stays up until the answer is seen
  task bus(input bit w, input logic [7:0] a, input logic [33:0] e);
    int n;
    bit ta, tw, tr, tv;
    if (w) bq.push_back(e[33:32]);
    else rq.push_back(e);
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= e[31:0];
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      tv = w ? bvalid : rvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (tv) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 50) timeout;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bus(1'b1, a, {r, d});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bus(1'b0, a, {r, d});
  endtask
  task wait_idle(input int n);
    int j;
    for (j = 0; j < n && running !== 1'b0; j++) @(negedge aclk);
    if (running !== 1'b0) timeout;
  endtask
  always @(posedge aclk) begin
    if (bvalid && bready) chk(bresp, bq.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (track && sp !== last_sp) chk(sp, sq.pop_front());
    last_sp <= sp;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 10; i++) rd(RA[i], RV[i], RESP_OKAY);
    rd(8'h40, 32'h0, RESP_DECERR);
    wr(8'h38, 32'h1, RESP_DECERR);
    b = 16'($random(seed)) & 16'h0EFF | 16'h1100;
    wr(OFS_TRIG, {16'h0, b}, RESP_OKAY);
    wr(OFS_TRIG, 32'h7001, RESP_SLVERR);
    rd(OFS_ERROR, ERR_RANGE, RESP_OKAY);
    rd(OFS_TRIG, {16'h0, b}, RESP_OKAY);
    wr(OFS_MODE, 32'h3, RESP_SLVERR);
    wr(OFS_MODE, 32'h10, RESP_OKAY);
    rd(OFS_MODE, 32'h10, RESP_OKAY);
    wr(OFS_CMD, 32'h1, RESP_OKAY);
    rd(OFS_MODE, 32'h11, RESP_OKAY);
    rd(OFS_OUT, {16'h0, b}, RESP_OKAY);
    chk({mode, lerr}, {LST_MODE_CURR, 1'b0});
    wr(OFS_MODE, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(lerr, 1'b1);
    wr(OFS_MODE, 32'h2, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({mode, lerr}, {LST_MODE_EXT, 1'b0});
    wr(OFS_CMD, 32'h2, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      v[i] = b + 16'((i + 1) * 256);
      wr(OFS_STEP, {16'h0, v[i]}, RESP_OKAY);
    end
    rd(OFS_STEP, 32'h3, RESP_OKAY);
    wr(OFS_DWELL, 32'd93, RESP_OKAY);
    wr(OFS_DWELL, 32'd93, RESP_OKAY);
    wr(OFS_CMD, 32'h4, RESP_SLVERR);
    rd(OFS_ERROR, ERR_CONFLICT, RESP_OKAY);
    wr(OFS_DWELL, 32'd93, RESP_OKAY);
    wr(OFS_COUNT, 32'h2, RESP_OKAY);
    wr(OFS_SKIP, 32'h1, RESP_OKAY);
    rd(OFS_QDATA, {16'd93, v[0]}, RESP_OKAY);
    sq = '{v[0], v[1], v[2], v[1], v[2]};
    track <= 1'b1;
    wr(OFS_CMD, 32'h4, RESP_OKAY);
    chk(off, 1'b1);
    rd(OFS_COUNT, 32'h0, RESP_SLVERR);
    wr(OFS_CMD, 32'h2, RESP_SLVERR);
    rd(OFS_STATUS, 32'hD, RESP_OKAY);
    rd(OFS_ERROR, ERR_CONFLICT, RESP_OKAY);
    wait_idle(20000);
    track <= 1'b0;
    chk({18'(sq.size()), sp}, {18'h0, v[2]});
    wr(OFS_COUNT, 32'h0, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      wr(OFS_CMD, 32'h4, RESP_OKAY);
      repeat (6000) @(posedge aclk);
      chk(running, 1'b1);
      wr(OFS_CMD, STOPS[i], RESP_OKAY);
      wait_idle(i == 1 ? 8000 : 3);
      if (i == 1) chk(sp, v[2]);
    end
    wr(OFS_QSTART, 32'h1, RESP_OKAY);
    wr(OFS_CMD, 32'h2, RESP_OKAY);
    chk(off, 1'b0);
    for (i = 3; i < 7; i++) rd(RA[i], 32'h0, RESP_OKAY);
    wr(OFS_STEP, {16'h0, v[0]}, RESP_OKAY);
    wr(OFS_STEP, {16'h0, v[1]}, RESP_OKAY);
    wr(OFS_DWELL, 32'd93, RESP_OKAY);
    wr(OFS_COUNT, 32'h1, RESP_OKAY);
    sq = '{v[0], v[1]};
    track <= 1'b1;
    wr(OFS_CMD, 32'h4, RESP_OKAY);
    wait_idle(8000);
    chk(34'(sq.size()), 34'h0);
    final_report;
  end
endmodule
